// ==== hdl/phy_led_pkg.sv ====
package phy_led_pkg;
	// ****************************************
	// Register map (index; byte address = index * 4)
	// ****************************************
	localparam int          ADDR_W              = 7;
	localparam logic [4:0]  REG_BASIC_CTRL_IDX  = 5'h00;
	localparam logic [4:0]  REG_LED_MODE_IDX    = 5'h1e;
	localparam logic [4:0]  REG_IND_STATUS_IDX  = 5'h1f;
	localparam int          DUPLEX_BIT_POS      = 8;
	localparam int          AUTONEG_BIT_POS     = 12;
	localparam int          MODE_LSB_POS        = 14;
	localparam logic [1:0]  MODE_RESET          = 2'h0;
	localparam logic        CTRL_BIT_RESET      = 1'h0;
	// ****************************************
	// Indicator modes
	// ****************************************
	typedef enum logic [1:0] {
		LED_MODE_00 = 2'h0,
		LED_MODE_01 = 2'h1,
		LED_MODE_10 = 2'h2,
		LED_MODE_11 = 2'h3
	} led_mode_t;
	// ****************************************
	// Timing
	// ****************************************
	localparam int          CLK_PERIOD_NS       = 40;
	localparam int          TOGGLE_HALF_US      = 50000;
	localparam int          TOGGLE_HALF_CYCLES  = TOGGLE_HALF_US * 1000 / CLK_PERIOD_NS;
	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic link_up;
		logic speed_100;
		logic full_duplex;
		logic collision;
		logic activity;
	} link_state_t;
	typedef struct packed {
		logic speed;
		logic duplex;
		logic col_act;
	} ind_levels_t;
endpackage

// ==== hdl/toggle_gen.sv ====
`timescale 1ns/1ps
module toggle_gen #(
	parameter int HALF_CYCLES = 1250000
) (
	input  wire logic pclk,    // Clock
	input  wire logic presetn, // Async reset, active low
	input  wire logic run,     // Blink while high
	output logic      phase    // Blink level
);
	localparam int CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
	localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);
	logic [CW-1:0] count;

	// Half period counter, idle at zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
		end else if (!run || count == LAST) begin
			count <= '0;
		end else begin
			count <= count + 1'b1;
		end
	end

	// Phase starts low (on) and flips each half period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= 1'b0;
		end else if (!run) begin
			phase <= 1'b0;
		end else if (count == LAST) begin
			phase <= ~phase;
		end
	end
endmodule // toggle_gen

// ==== hdl/phy_led_strap_powerdown.sv ====
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
// Operation
// - Latch duplex pin into control bit 8
// - Latch activity pin into autoneg bit 12
// - Duplex indicator low full in modes 00/01/10, toggles on collision in mode 01 only
// - Collision/activity indicator per mode register 1eh
// - Power-down input low stops normal operation
module phy_led_strap_powerdown #(
	parameter int TOGGLE_CYCLES = phy_led_pkg::TOGGLE_HALF_CYCLES
) (
	input  wire logic                        pclk,            // Clock 25 MHz
	input  wire logic                        presetn,         // Async reset, active low
	input  wire logic                        psel,            // APB select
	input  wire logic                        penable,         // APB enable
	input  wire logic                        pwrite,          // APB write
	input  wire logic [phy_led_pkg::ADDR_W-1:0] paddr,        // APB byte address
	input  wire logic [31:0]                 pwdata,          // APB write data
	input  wire logic [3:0]                  pstrb,           // APB byte strobes
	output logic      [31:0]                 prdata,          // APB read data
	output logic                             pready,          // APB ready
	output logic                             pslverr,         // APB error
	input  wire phy_led_pkg::link_state_t    link_state,      // Link status from PHY core
	input  wire logic                        power_down_n,    // Power down, active low
	output logic                             powered_down,    // Power-down state
	output logic                             duplex_ctrl,     // Duplex control bit
	output logic                             autoneg_enable_bit, // Autoneg enable bit
	output logic                             speed_indicator_o,  // Speed pin out
	output logic                             speed_indicator_oe, // Speed pin enable
	input  wire logic                        duplex_indicator_i, // Duplex pin in
	output logic                             duplex_indicator_o, // Duplex pin out
	output logic                             duplex_indicator_oe, // Duplex pin enable
	input  wire logic                        autoneg_strap_input, // Col/act pin in
	output logic                             collision_activity_indicator_o, // Col/act out
	output logic                             collision_activity_indicator_oe // Col/act enable
);
	// ****************************************
	// State
	// ****************************************
	logic                        strap_pending;
	phy_led_pkg::led_mode_t      led_mode;
	logic [1:0]                  blink;
	phy_led_pkg::ind_levels_t    next_ind;
	logic [4:0]                  reg_idx;
	logic                        idx_ok;
	logic                        acc_write;
	logic [31:0]                 next_rdata;

	assign reg_idx   = paddr[phy_led_pkg::ADDR_W-1:2];
	assign idx_ok    = (paddr[1:0] == 2'h0) &&
	                   (reg_idx == phy_led_pkg::REG_BASIC_CTRL_IDX ||
	                    reg_idx == phy_led_pkg::REG_LED_MODE_IDX ||
	                    reg_idx == phy_led_pkg::REG_IND_STATUS_IDX);
	assign acc_write = psel && penable && pwrite && idx_ok;
	assign pready    = penable;
	assign pslverr   = psel && penable && !idx_ok;

	// ****************************************
	// Strap capture at first edge after reset release
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_pending <= 1'b1;
		end else begin
			strap_pending <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			duplex_ctrl <= phy_led_pkg::CTRL_BIT_RESET;
		end else if (strap_pending) begin
			duplex_ctrl <= duplex_indicator_i;
		end else if (acc_write && pstrb[1] &&
		             reg_idx == phy_led_pkg::REG_BASIC_CTRL_IDX) begin
			duplex_ctrl <= pwdata[phy_led_pkg::DUPLEX_BIT_POS];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			autoneg_enable_bit <= phy_led_pkg::CTRL_BIT_RESET;
		end else if (strap_pending) begin
			autoneg_enable_bit <= autoneg_strap_input;
		end else if (acc_write && pstrb[1] &&
		             reg_idx == phy_led_pkg::REG_BASIC_CTRL_IDX) begin
			autoneg_enable_bit <= pwdata[phy_led_pkg::AUTONEG_BIT_POS];
		end
	end

	// ****************************************
	// Mode register
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			led_mode <= phy_led_pkg::led_mode_t'(phy_led_pkg::MODE_RESET);
		end else if (acc_write && pstrb[1] &&
		             reg_idx == phy_led_pkg::REG_LED_MODE_IDX) begin
			led_mode <= phy_led_pkg::led_mode_t'(
			            pwdata[phy_led_pkg::MODE_LSB_POS +: 2]);
		end
	end

	// ****************************************
	// Read data, captured in setup phase
	// ****************************************
	always_comb begin
		next_rdata = 32'h0;
		case (reg_idx)
			phy_led_pkg::REG_BASIC_CTRL_IDX: begin
				next_rdata[phy_led_pkg::DUPLEX_BIT_POS]  = duplex_ctrl;
				next_rdata[phy_led_pkg::AUTONEG_BIT_POS] = autoneg_enable_bit;
			end
			phy_led_pkg::REG_LED_MODE_IDX: begin
				next_rdata[phy_led_pkg::MODE_LSB_POS +: 2] = led_mode;
			end
			phy_led_pkg::REG_IND_STATUS_IDX: begin
				next_rdata[2:0] = {speed_indicator_o, duplex_indicator_o,
				                   collision_activity_indicator_o};
				next_rdata[3]   = powered_down;
				next_rdata[8:4] = link_state;
			end
			default: begin
				next_rdata = 32'h0;
			end
		endcase
		if (!idx_ok) begin
			next_rdata = 32'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			prdata <= next_rdata;
		end
	end

	// ****************************************
	// Power down
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			powered_down <= 1'b0;
		end else begin
			powered_down <= !power_down_n;
		end
	end

	// ****************************************
	// Blink generators: 0 collision, 1 activity
	// ****************************************
	for (genvar g = 0; g < 2; g++) begin : g_blink
		logic run;
		assign run = power_down_n && ((g == 0) ? link_state.collision
		                                        : link_state.activity);
		toggle_gen #(
			.HALF_CYCLES (TOGGLE_CYCLES)
		) u_toggle (
			.pclk    (pclk),
			.presetn (presetn),
			.run     (run),
			.phase   (blink[g])
		);
	end

	// ****************************************
	// Indicator levels, all active low
	// ****************************************
	always_comb begin
		next_ind = '{speed: 1'b1, duplex: 1'b1, col_act: 1'b1};
		case (led_mode)
			phy_led_pkg::LED_MODE_00: begin
				next_ind.speed   = !link_state.speed_100;
				next_ind.duplex  = !link_state.full_duplex;
				next_ind.col_act = !link_state.collision;
			end
			phy_led_pkg::LED_MODE_01: begin
				next_ind.speed   = !link_state.speed_100;
				next_ind.duplex  = link_state.collision ? blink[0]
				                                        : !link_state.full_duplex;
				next_ind.col_act = link_state.activity ? blink[1] : 1'b1;
			end
			phy_led_pkg::LED_MODE_10: begin
				next_ind.speed   = !(link_state.link_up && link_state.speed_100);
				next_ind.duplex  = !link_state.full_duplex;
				next_ind.col_act = link_state.activity ? blink[1] : 1'b1;
			end
			default: begin
				next_ind = '{speed: 1'b1, duplex: 1'b1, col_act: 1'b1};
			end
		endcase
		if (!power_down_n) begin
			next_ind = '{speed: 1'b1, duplex: 1'b1, col_act: 1'b1};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			speed_indicator_o              <= 1'b1;
			duplex_indicator_o             <= 1'b1;
			collision_activity_indicator_o <= 1'b1;
		end else begin
			speed_indicator_o              <= next_ind.speed;
			duplex_indicator_o             <= next_ind.duplex;
			collision_activity_indicator_o <= next_ind.col_act;
		end
	end

	// Strap pins released until sampled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			speed_indicator_oe              <= 1'b0;
			duplex_indicator_oe             <= 1'b0;
			collision_activity_indicator_oe <= 1'b0;
		end else begin
			speed_indicator_oe              <= 1'b1;
			duplex_indicator_oe             <= !strap_pending;
			collision_activity_indicator_oe <= !strap_pending;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_duplex_strap: assert property (@(posedge pclk) disable iff (!presetn)
		strap_pending |=> (duplex_ctrl == $past(duplex_indicator_i)) && !duplex_indicator_oe)
		else $error("duplex strap not latched");
	a_aneg_strap: assert property (@(posedge pclk) disable iff (!presetn)
		strap_pending |=> autoneg_enable_bit == $past(autoneg_strap_input) ##1
		collision_activity_indicator_oe)
		else $error("autoneg strap not latched");
	a_duplex_level: assert property (@(posedge pclk) disable iff (!presetn)
		(power_down_n && led_mode != phy_led_pkg::LED_MODE_11 &&
		 !(led_mode == phy_led_pkg::LED_MODE_01 && link_state.collision))
		|=> duplex_indicator_o == !$past(link_state.full_duplex))
		else $error("duplex indicator wrong");
	a_colact_mode0: assert property (@(posedge pclk) disable iff (!presetn)
		(power_down_n && led_mode == phy_led_pkg::LED_MODE_00)
		|=> collision_activity_indicator_o == !$past(link_state.collision))
		else $error("collision indicator wrong");
	a_colact_idle: assert property (@(posedge pclk) disable iff (!presetn)
		(led_mode != phy_led_pkg::LED_MODE_00 && !link_state.activity)
		|=> collision_activity_indicator_o)
		else $error("activity indicator lit when idle");
	a_powerdown_off: assert property (@(posedge pclk) disable iff (!presetn)
		!power_down_n |=> powered_down && speed_indicator_o && duplex_indicator_o &&
		collision_activity_indicator_o)
		else $error("power down not honoured");
	a_speed_mode10: assert property (@(posedge pclk) disable iff (!presetn)
		(power_down_n && led_mode == phy_led_pkg::LED_MODE_10)
		|=> speed_indicator_o == !$past(link_state.link_up && link_state.speed_100))
		else $error("speed indicator wrong in mode 10");
	a_speed_mode01: assert property (@(posedge pclk) disable iff (!presetn)
		(power_down_n && led_mode == phy_led_pkg::LED_MODE_01)
		|=> speed_indicator_o == !$past(link_state.speed_100))
		else $error("speed indicator wrong in mode 01");
endmodule // phy_led_strap_powerdown

// ==== sim/tb_phy_led_strap_powerdown.sv ====
`timescale 1ns/1ps
module tb_phy_led_strap_powerdown;
	// ****************************************
	// Stimulus and design
	// ****************************************
	logic                      pclk         = 1'b0;
	logic                      presetn      = 1'b0;
	logic                      psel         = 1'b0;
	logic                      penable      = 1'b0;
	logic                      pwrite       = 1'b0;
	logic [6:0]                paddr        = 7'h00;
	logic [31:0]               pwdata       = 32'h0;
	logic [3:0]                pstrb        = 4'h0;
	phy_led_pkg::link_state_t  link_state   = '0;
	logic                      power_down_n = 1'b1;
	logic                      strap_d      = 1'b0;
	logic                      strap_a      = 1'b0;
	logic [31:0]               prdata;
	logic                      pready, pslverr, powered_down, duplex_ctrl, autoneg_enable_bit;
	logic                      spd_o, spd_oe, dup_o, dup_oe, col_o, col_oe;
	wire                       dup_pin = dup_oe ? dup_o : strap_d;
	wire                       col_pin = col_oe ? col_o : strap_a;
	int                        n_mismatch = 0;
	int                        cmp_count  = 0;
	int                        cyc        = 0;
	logic [31:0]               rd;
	logic                      err;

	always #20 pclk = ~pclk;

	phy_led_strap_powerdown #(.TOGGLE_CYCLES(4)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link_state(link_state), .power_down_n(power_down_n),
		.powered_down(powered_down), .duplex_ctrl(duplex_ctrl),
		.autoneg_enable_bit(autoneg_enable_bit), .speed_indicator_o(spd_o),
		.speed_indicator_oe(spd_oe), .duplex_indicator_i(dup_pin),
		.duplex_indicator_o(dup_o), .duplex_indicator_oe(dup_oe),
		.autoneg_strap_input(col_pin), .collision_activity_indicator_o(col_o),
		.collision_activity_indicator_oe(col_oe));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic end_of_test;
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [6:0] a, input logic [31:0] d,
			input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask

	task automatic set_ls(input logic [4:0] v);
		@(posedge pclk);
		link_state <= phy_led_pkg::link_state_t'(v);
		repeat (2) @(posedge pclk);
		#1;
	endtask

	function automatic logic [2:0] exp_ind(input logic [1:0] m, input logic [4:0] v);
		case (m)
			2'h0: exp_ind = {~v[3], ~v[2], ~v[1]};
			2'h1: exp_ind = {~v[3], ~v[2], 1'b1};
			2'h2: exp_ind = {~(v[4] & v[3]), ~v[2], 1'b1};
			default: exp_ind = 3'h7;
		endcase
	endfunction

	task automatic do_reset(input logic d, input logic a);
		@(posedge pclk);
		presetn <= 1'b0; strap_d <= d; strap_a <= a;
		repeat (3) @(posedge pclk);
		#1;
		check(32'({spd_o, dup_o, col_o, spd_oe, dup_oe, col_oe}), 32'h38);
		@(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		#1;
		check(32'(duplex_ctrl), 32'(d));
		check(32'(autoneg_enable_bit), 32'(a));
		check(32'({spd_oe, dup_oe, col_oe}), 32'h7);
		apb(1'b0, 7'h00, 32'h0, 4'h0);
		check(rd, 32'(a) << 12 | 32'(d) << 8);
		apb(1'b0, 7'h78, 32'h0, 4'h0);
		check(rd, 32'h0);
	endtask

	task automatic blink(input logic [1:0] m, input logic [3:0] exp);
		logic [3:0] seen;
		seen = 4'h0;
		apb(1'b1, 7'h78, {16'h0, m, 14'h0}, 4'hf);
		set_ls(5'h00);
		set_ls(5'h03);
		repeat (12) begin
			@(posedge pclk);
			#1;
			seen = seen | {~dup_o, dup_o, ~col_o, col_o};
		end
		check(32'(seen[3:2]), 32'(exp[3:2]));
		check(32'(seen[1:0]), 32'(exp[1:0]));
	endtask

	// ****************************************
	// Sequence
	// ****************************************
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			n_mismatch++;
			end_of_test;
		end
	end

	initial begin
		logic [2:0] iv, ev;
		do_reset(1'b1, 1'b0);
		apb(1'b1, 7'h00, 32'h1000, 4'hf);
		check(32'({duplex_ctrl, autoneg_enable_bit}), 32'h1);
		apb(1'b0, 7'h00, 32'h0, 4'h0);
		check(rd, 32'h1000);
		apb(1'b1, 7'h78, 32'hc000, 4'h1);
		apb(1'b0, 7'h78, 32'h0, 4'h0);
		check(rd, 32'h0);
		apb(1'b0, 7'h40, 32'h0, 4'h0);
		check(32'({err, rd[30:0]}), 32'h80000000);
		apb(1'b1, 7'h79, 32'hc000, 4'hf);
		check(32'(err), 32'h1);
		apb(1'b0, 7'h78, 32'h0, 4'h0);
		check(rd, 32'h0);
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, 7'h78, 32'(m) << 14, 4'hf);
			for (int i = 0; i < 32; i++) begin
				if (m == 0 || i % 4 == 0) begin
					set_ls(5'(i));
					iv = {spd_o, dup_o, col_o};
					ev = exp_ind(2'(m), 5'(i));
					check(32'(iv[2]), 32'(ev[2]));
					check(32'(iv[1]), 32'(ev[1]));
					check(32'(iv[0]), 32'(ev[0]));
				end
			end
		end
		apb(1'b1, 7'h78, 32'h0, 4'hf);
		set_ls(5'h1a);
		apb(1'b0, 7'h7c, 32'h0, 4'h0);
		check(rd, 32'h1a2);
		@(posedge pclk);
		power_down_n <= 1'b0;
		repeat (2) @(posedge pclk);
		#1;
		check(32'({powered_down, spd_o, dup_o, col_o}), 32'hf);
		apb(1'b0, 7'h7c, 32'h0, 4'h0);
		check(rd, 32'h1af);
		@(posedge pclk);
		power_down_n <= 1'b1;
		repeat (2) @(posedge pclk);
		#1;
		check(32'({powered_down, spd_o, dup_o, col_o}), 32'h2);
		blink(2'h1, 4'hf);
		blink(2'h2, 4'h7);
		do_reset(1'b0, 1'b1);
		end_of_test;
	end
endmodule // tb_phy_led_strap_powerdown
